// ---- hdl/exec_pkg.sv ----
`default_nettype none
package exec_pkg;

    // ****************************************
    // Widths and sizes
    // ****************************************
    localparam int DW        = 16;
    localparam int RW        = 4;
    localparam int NREG      = 16;
    localparam int MEM_AW    = 6;
    localparam int MEM_WORDS = 64;
    localparam int AMT_W     = 5;
    localparam int BYTE_W    = 8;
    localparam int SLIT_W    = 10;

    // ****************************************
    // Fixed values
    // ****************************************
    localparam logic [RW-1:0]     DEFAULT_DEFAULT_WORKING_REGISTER = 4'h0;
    localparam logic [MEM_AW-1:0] SP_RESET     = 6'h20;
    localparam logic [MEM_AW-1:0] SP_STEP      = 6'h01;
    localparam logic [MEM_AW-1:0] ADDR_STEP    = 6'h01;
    localparam logic [DW-1:0]     WORD_ZERO    = 16'h0000;
    localparam logic [AMT_W-1:0]  SINGLE_SHIFT = 5'h01;

    // ****************************************
    // Operations and sequencing
    // ****************************************
    typedef enum logic [4:0] {
        op_lsr_file_to_default_working_register,
        op_lsr_reg,
        op_lsr_by_reg,
        op_lsr_by_lit,
        op_copy_lit16,
        op_byte_copy_lit8,
        op_copy_load_offset,
        op_copy_store_offset,
        op_double_copy_to_mem,
        op_double_copy_from_mem,
        op_signed_signed_product,
        op_signed_unsigned_product,
        op_unsigned_signed_product,
        op_unsigned_unsigned_product,
        op_signed_unsigned_product_lit,
        op_unsigned_unsigned_product_lit,
        op_pop_file,
        op_pop_reg,
        op_pop_double,
        op_push_reg,
        op_push_double
    } op_t;

    typedef enum logic {
        st_idle,
        st_second
    } state_t;

endpackage
`default_nettype wire

// ---- hdl/lsr_shifter.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsr_shifter (
    // Operand
    input  wire logic [exec_pkg::DW-1:0]    value,
    input  wire logic [exec_pkg::AMT_W-1:0] amount,
    // Result
    output logic      [exec_pkg::DW-1:0]    result,
    output logic                            carry_out
);
    import exec_pkg::*;

    logic [DW:0] ext;

    // Extra low bit catches the last bit shifted out; large amounts give zero
    assign ext       = {value, 1'b0} >> amount;
    assign result    = ext[DW:1];
    assign carry_out = ext[0];

endmodule // lsr_shifter
`default_nettype wire

// ---- hdl/pair_multiplier.sv ----
`timescale 1ns/1ps
`default_nettype none
module pair_multiplier (
    // Operands
    input  wire logic [exec_pkg::DW-1:0]   base_val,
    input  wire logic [exec_pkg::DW-1:0]   src_val,
    input  wire logic                      base_signed,
    input  wire logic                      src_signed,
    // Result
    output logic      [2*exec_pkg::DW-1:0] product
);
    import exec_pkg::*;

    logic signed [DW:0]     base_ext;
    logic signed [DW:0]     src_ext;
    logic signed [2*DW+1:0] full;

    // One extra bit per operand lets a single signed multiplier cover all four mixes
    assign base_ext = {base_signed & base_val[DW-1], base_val};
    assign src_ext  = {src_signed & src_val[DW-1], src_val};
    assign full     = base_ext * src_ext;
    assign product  = full[2*DW-1:0];

endmodule // pair_multiplier
`default_nettype wire

// ---- hdl/exec_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module exec_core (
    // Clock, reset, enable
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    // Operation request
    input  wire logic                         op_valid,
    input  wire exec_pkg::op_t                op_code,
    input  wire logic [exec_pkg::RW-1:0]      base_sel,
    input  wire logic [exec_pkg::RW-1:0]      src_sel,
    input  wire logic [exec_pkg::RW-1:0]      dst_sel,
    input  wire logic [exec_pkg::DW-1:0]      literal,
    input  wire logic [exec_pkg::SLIT_W-1:0]  slit,
    input  wire logic [exec_pkg::MEM_AW-1:0]  file_addr,
    input  wire logic [exec_pkg::RW-1:0]      view_sel,
    // Status
    output logic                              busy,
    output logic                              done,
    output logic                              carry_flag,
    output logic                              negative_flag,
    output logic                              overflow_flag,
    output logic                              zero_flag,
    output logic                              digit_carry_flag,
    output logic      [exec_pkg::DW-1:0]      view_data,
    output logic      [exec_pkg::MEM_AW-1:0]  stack_ptr
);
    import exec_pkg::*;
    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic [RW-1:0] pair_lo(input logic [RW-1:0] sel);
        pair_lo = {sel[RW-1:1], 1'b0};
    endfunction
    function automatic logic [RW-1:0] pair_hi(input logic [RW-1:0] sel);
        pair_hi = {sel[RW-1:1], 1'b1};
    endfunction
    function automatic logic is_double(input op_t op);
        is_double = (op == op_double_copy_to_mem) || (op == op_double_copy_from_mem) ||
                    (op == op_pop_double) || (op == op_push_double);
    endfunction
    function automatic logic is_product(input op_t op);
        is_product = (op >= op_signed_signed_product) && (op <= op_unsigned_unsigned_product_lit);
    endfunction
    // ****************************************
    // State
    // ****************************************
    logic [DW-1:0]     regs_reg [NREG];
    logic [DW-1:0]     mem_reg  [MEM_WORDS];
    logic [MEM_AW-1:0] sp_reg;
    state_t            state_reg;
    op_t               op2_reg;
    logic [RW-1:0]     idx2_reg;
    logic [MEM_AW-1:0] addr2_reg;
    logic [DW-1:0]     word2_reg;
    logic              busy_reg;
    logic              done_reg;
    logic              c_reg, n_reg, ov_reg, z_reg, dc_reg;
    logic [DW-1:0]     view_reg;
    // ****************************************
    // Operand fetch and datapath
    // ****************************************
    logic              issue;
    logic [DW-1:0]     b_val, s_val, f_val, off_sum, sh_in, sh_out, mul_src;
    logic [AMT_W-1:0]  sh_amt;
    logic              sh_carry, mul_bs, signed_signed_product;
    logic [2*DW-1:0]   product;
    logic [MEM_AW-1:0] off_addr, sp_dec;
    assign issue    = op_valid && (state_reg == st_idle);
    assign b_val    = regs_reg[base_sel];
    assign s_val    = regs_reg[src_sel];
    assign f_val    = mem_reg[file_addr];
    assign off_sum  = b_val + {{(DW-SLIT_W){slit[SLIT_W-1]}}, slit};
    assign off_addr = off_sum[MEM_AW-1:0];
    assign sp_dec   = sp_reg - SP_STEP;
    always_comb begin
        sh_in  = b_val;
        sh_amt = SINGLE_SHIFT;
        case (op_code)
            op_lsr_file_to_default_working_register: sh_in = f_val;
            op_lsr_reg:          sh_in = s_val;
            op_lsr_by_reg:       sh_amt = s_val[AMT_W-1:0];
            op_lsr_by_lit:       sh_amt = literal[AMT_W-1:0];
            default:             sh_in = b_val;
        endcase
    end
    lsr_shifter u_shift (
        .value     (sh_in),
        .amount    (sh_amt),
        .result    (sh_out),
        .carry_out (sh_carry)
    );
    assign mul_bs  = (op_code == op_signed_signed_product) || (op_code == op_signed_unsigned_product) ||
                     (op_code == op_signed_unsigned_product_lit);
    assign signed_signed_product  = (op_code == op_signed_signed_product) || (op_code == op_unsigned_signed_product);
    assign mul_src = ((op_code == op_signed_unsigned_product_lit) || (op_code == op_unsigned_unsigned_product_lit))
                   ? {{(DW-AMT_W){1'b0}}, literal[AMT_W-1:0]} : s_val;
    pair_multiplier u_mul (
        .base_val    (b_val),
        .src_val     (mul_src),
        .base_signed (mul_bs),
        .src_signed  (signed_signed_product),
        .product     (product)
    );
    // ****************************************
    // Operation decode
    // ****************************************
    logic              wr_en, wr2_en, mw_en, flag_c_wr, flag_nz_wr, go_second;
    logic [RW-1:0]     wr_idx, wr2_idx, idx2_next;
    logic [DW-1:0]     wr_data, wr2_data, mw_data, word2_next;
    logic [MEM_AW-1:0] mw_addr, sp_next, addr2_next;
    logic              c_next, z_next;
    always_comb begin
        wr_en = 1'b0; wr_idx = DEFAULT_DEFAULT_WORKING_REGISTER; wr_data = WORD_ZERO;
        wr2_en = 1'b0; wr2_idx = DEFAULT_DEFAULT_WORKING_REGISTER; wr2_data = WORD_ZERO;
        mw_en = 1'b0; mw_addr = file_addr; mw_data = WORD_ZERO;
        sp_next = sp_reg; go_second = 1'b0;
        flag_c_wr = 1'b0; flag_nz_wr = 1'b0;
        c_next = sh_carry; z_next = (sh_out == WORD_ZERO);
        idx2_next = idx2_reg; addr2_next = addr2_reg; word2_next = word2_reg;
        if (state_reg == st_second) begin
            case (op2_reg)
                op_double_copy_to_mem: begin
                    mw_en = 1'b1; mw_addr = addr2_reg; mw_data = word2_reg;
                end
                op_double_copy_from_mem: begin
                    wr_en = 1'b1; wr_idx = idx2_reg; wr_data = mem_reg[addr2_reg];
                end
                op_pop_double: begin
                    sp_next = sp_dec; wr_en = 1'b1; wr_idx = idx2_reg; wr_data = mem_reg[sp_dec];
                end
                op_push_double: begin
                    mw_en = 1'b1; mw_addr = sp_reg; mw_data = word2_reg; sp_next = sp_reg + SP_STEP;
                end
                default: wr_en = 1'b0;
            endcase
        end else if (issue) begin
            case (op_code)
                op_lsr_file_to_default_working_register: begin
                    wr_en = 1'b1; wr_idx = DEFAULT_DEFAULT_WORKING_REGISTER; wr_data = sh_out;
                    flag_c_wr = 1'b1; flag_nz_wr = 1'b1;
                end
                op_lsr_reg: begin
                    wr_en = 1'b1; wr_idx = dst_sel; wr_data = sh_out;
                    flag_c_wr = 1'b1; flag_nz_wr = 1'b1;
                end
                op_lsr_by_reg, op_lsr_by_lit: begin
                    wr_en = 1'b1; wr_idx = dst_sel; wr_data = sh_out; flag_nz_wr = 1'b1;
                end
                op_copy_lit16: begin
                    wr_en = 1'b1; wr_idx = dst_sel; wr_data = literal;
                end
                op_byte_copy_lit8: begin
                    wr_en = 1'b1; wr_idx = dst_sel;
                    wr_data = {regs_reg[dst_sel][DW-1:BYTE_W], literal[BYTE_W-1:0]};
                end
                op_copy_load_offset: begin
                    wr_en = 1'b1; wr_idx = dst_sel; wr_data = mem_reg[off_addr];
                end
                op_copy_store_offset: begin
                    mw_en = 1'b1; mw_addr = off_addr; mw_data = s_val;
                end
                op_double_copy_to_mem: begin
                    mw_en = 1'b1; mw_addr = regs_reg[dst_sel][MEM_AW-1:0];
                    mw_data = regs_reg[pair_lo(src_sel)];
                    go_second = 1'b1; addr2_next = regs_reg[dst_sel][MEM_AW-1:0] + ADDR_STEP;
                    word2_next = regs_reg[pair_hi(src_sel)];
                end
                op_double_copy_from_mem: begin
                    wr_en = 1'b1; wr_idx = pair_lo(dst_sel); wr_data = mem_reg[s_val[MEM_AW-1:0]];
                    go_second = 1'b1; idx2_next = pair_hi(dst_sel);
                    addr2_next = s_val[MEM_AW-1:0] + ADDR_STEP;
                end
                op_signed_signed_product, op_signed_unsigned_product, op_unsigned_signed_product,
                op_unsigned_unsigned_product, op_signed_unsigned_product_lit, op_unsigned_unsigned_product_lit: begin
                    wr_en = 1'b1; wr_idx = pair_lo(dst_sel); wr_data = product[DW-1:0];
                    wr2_en = 1'b1; wr2_idx = pair_hi(dst_sel); wr2_data = product[2*DW-1:DW];
                end
                op_pop_file: begin
                    sp_next = sp_dec; mw_en = 1'b1; mw_data = mem_reg[sp_dec];
                end
                op_pop_reg: begin
                    sp_next = sp_dec; wr_en = 1'b1; wr_idx = dst_sel; wr_data = mem_reg[sp_dec];
                end
                op_pop_double: begin
                    // Pushed low first, so the upper register comes off first
                    sp_next = sp_dec; wr_en = 1'b1; wr_idx = pair_hi(dst_sel); wr_data = mem_reg[sp_dec];
                    go_second = 1'b1; idx2_next = pair_lo(dst_sel);
                end
                op_push_reg: begin
                    mw_en = 1'b1; mw_addr = sp_reg; mw_data = s_val; sp_next = sp_reg + SP_STEP;
                end
                op_push_double: begin
                    mw_en = 1'b1; mw_addr = sp_reg; mw_data = regs_reg[pair_lo(src_sel)];
                    sp_next = sp_reg + SP_STEP; go_second = 1'b1;
                    word2_next = regs_reg[pair_hi(src_sel)];
                end
                default: wr_en = 1'b0;
            endcase
        end
    end
    // ****************************************
    // Storage updates
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NREG; i++) regs_reg[i] <= WORD_ZERO;
        end else if (ce) begin
            if (wr_en) regs_reg[wr_idx] <= wr_data;
            if (wr2_en) regs_reg[wr2_idx] <= wr2_data;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < MEM_WORDS; i++) mem_reg[i] <= WORD_ZERO;
        end else if (ce && mw_en) begin
            mem_reg[mw_addr] <= mw_data;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) sp_reg <= SP_RESET;
        else if (ce) sp_reg <= sp_next;
    end
    // Single shifts clear OV and load C; N takes result bit 15, which only a shift by zero can leave set
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            c_reg <= 1'b0; n_reg <= 1'b0; ov_reg <= 1'b0; z_reg <= 1'b0; dc_reg <= 1'b0;
        end else if (ce) begin
            if (flag_c_wr) begin
                c_reg  <= c_next;
                ov_reg <= 1'b0;
            end
            if (flag_nz_wr) begin
                n_reg <= sh_out[DW-1];
                z_reg <= z_next;
            end
        end
    end
    // ****************************************
    // Sequencing
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= st_idle; busy_reg <= 1'b0; done_reg <= 1'b0;
            op2_reg <= op_lsr_file_to_default_working_register; idx2_reg <= DEFAULT_DEFAULT_WORKING_REGISTER;
            addr2_reg <= SP_RESET; word2_reg <= WORD_ZERO;
        end else if (ce) begin
            if (go_second) begin
                state_reg <= st_second; busy_reg <= 1'b1; done_reg <= 1'b0;
                op2_reg <= op_code; idx2_reg <= idx2_next;
                addr2_reg <= addr2_next; word2_reg <= word2_next;
            end else begin
                done_reg  <= (state_reg == st_second) || issue;
                state_reg <= st_idle; busy_reg <= 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) view_reg <= WORD_ZERO;
        else if (ce) view_reg <= regs_reg[view_sel];
    end
    assign busy = busy_reg; assign done = done_reg; assign stack_ptr = sp_reg; assign view_data = view_reg;
    assign carry_flag = c_reg; assign negative_flag = n_reg; assign overflow_flag = ov_reg;
    assign zero_flag = z_reg; assign digit_carry_flag = dc_reg;
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic go;
    assign go = ce && issue;
    a_lsr_file_flags: assert property (go && op_code == op_lsr_file_to_default_working_register |=>
        regs_reg[DEFAULT_DEFAULT_WORKING_REGISTER] == ($past(f_val) >> 1) && c_reg == $past(f_val[0]) && !n_reg && !ov_reg)
        else $error("single shift of memory word wrong");
    a_lsr_reg_one: assert property (go && op_code == op_lsr_reg |=>
        regs_reg[$past(dst_sel)] == ($past(s_val) >> 1) && z_reg == ($past(s_val) <= 16'h0001))
        else $error("single shift of register wrong");
    a_lsr_amount_nz: assert property (go && op_code == op_lsr_by_reg |=>
        regs_reg[$past(dst_sel)] == ($past(b_val) >> $past(s_val[AMT_W-1:0])) && $stable(c_reg) && $stable(ov_reg))
        else $error("shift by register amount wrong");
    a_lsr_literal_nz: assert property (go && op_code == op_lsr_by_lit |=>
        regs_reg[$past(dst_sel)] == ($past(b_val) >> $past(literal[AMT_W-1:0])) && $stable(c_reg))
        else $error("shift by literal wrong");
    a_lit16_load: assert property (go && op_code == op_copy_lit16 |=>
        regs_reg[$past(dst_sel)] == $past(literal) && $stable({c_reg, n_reg, ov_reg, z_reg}))
        else $error("literal load wrong");
    a_lit8_keep_high: assert property (go && op_code == op_byte_copy_lit8 |=>
        regs_reg[$past(dst_sel)][DW-1:BYTE_W] == $past(regs_reg[dst_sel][DW-1:BYTE_W]) &&
        regs_reg[$past(dst_sel)][BYTE_W-1:0] == $past(literal[BYTE_W-1:0]))
        else $error("byte literal load wrong");
    a_offset_load: assert property (go && op_code == op_copy_load_offset |=>
        regs_reg[$past(dst_sel)] == $past(mem_reg[off_addr])) else $error("offset load wrong");
    a_offset_store: assert property (go && op_code == op_copy_store_offset |=>
        mem_reg[$past(off_addr)] == $past(s_val)) else $error("offset store wrong");
    sequence s_double_start;
        go && is_double(op_code) ##1 ce;
    endsequence
    sequence s_double_finish;
        busy_reg && !done_reg ##1 done_reg && !busy_reg;
    endsequence
    a_double_two_cycles: assert property (s_double_start |-> s_double_finish)
        else $error("double word op not two cycles");
    a_single_one_cycle: assert property (go && !is_double(op_code) |=> done_reg && !busy_reg)
        else $error("single op not one cycle");
    a_product_pair: assert property (go && is_product(op_code) |=>
        {regs_reg[pair_hi($past(dst_sel))], regs_reg[pair_lo($past(dst_sel))]} == $past(product))
        else $error("product pair wrong");
    a_push_advance: assert property (go && op_code == op_push_reg |=>
        sp_reg == $past(sp_reg) + SP_STEP && mem_reg[$past(sp_reg)] == $past(s_val))
        else $error("push wrong");
    a_pop_step_back: assert property (go && op_code == op_pop_reg |=>
        sp_reg == $past(sp_dec) && regs_reg[$past(dst_sel)] == $past(mem_reg[sp_dec]))
        else $error("pop wrong");
endmodule // exec_core
`default_nettype wire

// ---- bench/cpu_shift_move_mul_stack_ops_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_shift_move_mul_stack_ops_bench;
    import exec_pkg::*;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic              sys_clk = 1'b0;
    logic              rst, ce, op_valid, busy, done, cf, nf, vf, zf, dcf;
    op_t               op_code;
    logic [RW-1:0]     base_sel, src_sel, dst_sel, view_sel;
    logic [DW-1:0]     literal, view_data, a, b, s, t, r3;
    logic [SLIT_W-1:0] slit;
    logic [MEM_AW-1:0] file_addr, stack_ptr;
    logic [4:0]        fl;
    logic [31:0]       p;
    int                miscompares, checks;
    op_t               pc [6] = '{op_signed_signed_product, op_signed_unsigned_product, op_unsigned_signed_product,
                                  op_unsigned_unsigned_product, op_signed_unsigned_product_lit,
                                  op_unsigned_unsigned_product_lit};
    logic [5:0]        sxs = 6'h13;
    logic [5:0]        sys = 6'h05;

    always #50 sys_clk = ~sys_clk;

    exec_core DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce), .op_valid(op_valid), .op_code(op_code),
        .base_sel(base_sel), .src_sel(src_sel), .dst_sel(dst_sel), .literal(literal), .slit(slit),
        .file_addr(file_addr), .view_sel(view_sel), .busy(busy), .done(done), .carry_flag(cf),
        .negative_flag(nf), .overflow_flag(vf), .zero_flag(zf), .digit_carry_flag(dcf),
        .view_data(view_data), .stack_ptr(stack_ptr));

    // ****************************************
    // Expectation helpers
    // ****************************************
    function automatic logic [DW-1:0] shr(input logic [DW-1:0] v, input logic [4:0] n);
        return (n >= 5'h10) ? 16'h0000 : v >> n;
    endfunction

    // Sign-extend to 34 bits so every signedness mix fits one signed multiply
    function automatic logic [31:0] mulx(input logic [DW-1:0] x, y, input logic sx, sy);
        logic signed [33:0] ex, ey;
        ex = {{18{sx & x[15]}}, x};
        ey = {{18{sy & y[15]}}, y};
        return 32'(ex * ey);
    endfunction

    // Flag vector is {C, N, OV, Z, DC}
    function automatic logic [4:0] nz(input logic [DW-1:0] v);
        return {fl[4], v[15], fl[2], v == 16'h0000, fl[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic op(input op_t c, input logic [RW-1:0] bs, ss, ds, input logic [DW-1:0] lit,
                      input logic [SLIT_W-1:0] sl, input logic [MEM_AW-1:0] fa, input int cyc);
        int n;
        @(posedge sys_clk);
        op_valid  <= 1'b1;
        op_code   <= c;
        base_sel  <= bs;
        src_sel   <= ss;
        dst_sel   <= ds;
        literal   <= lit;
        slit      <= sl;
        file_addr <= fa;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
        n = 1;
        chk(32'(busy), 32'(cyc == 2));
        while (done !== 1'b1 && n < 8) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 8) begin
            miscompares++;
            end_sim;
        end
        chk(32'(n), 32'(cyc));
        chk(32'({cf, nf, vf, zf, dcf}), 32'(fl));
    endtask

    task automatic rd(input logic [RW-1:0] r, input logic [DW-1:0] exp);
        @(posedge sys_clk);
        view_sel <= r;
        @(posedge sys_clk);
        #1;
        chk(32'(view_data), 32'(exp));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst, ce, op_valid, base_sel, src_sel, dst_sel, view_sel} = {2'b11, 1'b0, 16'h0000};
        {literal, slit, file_addr, fl, miscompares, checks} = '0;
        op_code = op_copy_lit16;
        a = 16'($urandom(56));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk(32'(stack_ptr), 32'(SP_RESET));
        for (int k = 0; k < 4; k++) begin
            a = 16'($urandom);
            b = 16'($urandom);
            s = (k == 0) ? 16'h0010 : (k == 1) ? 16'h0000 : 16'($urandom);
            if (k == 0) begin
                a = 16'h0001;
                b = 16'h8000;
            end
            op(op_copy_lit16, 0, 0, 1, a, 0, 0, 1);
            op(op_copy_lit16, 0, 0, 2, b, 0, 0, 1);
            op(op_copy_lit16, 0, 0, 5, s, 0, 0, 1);
            rd(1, a);
            fl = {a[0], 3'b000, 1'b0} | {3'b000, (a >> 1) == 16'h0000, 1'b0};
            r3 = a >> 1;
            op(op_lsr_reg, 0, 1, 3, 0, 0, 0, 1);
            rd(3, r3);
            t = shr(b, s[4:0]);
            fl = nz(t);
            op(op_lsr_by_reg, 2, 5, 4, 0, 0, 0, 1);
            rd(4, t);
            t = shr(a, s[4:0]);
            fl = nz(t);
            op(op_lsr_by_lit, 1, 0, 6, s, 0, 0, 1);
            rd(6, t);
            op(op_byte_copy_lit8, 0, 0, 3, b, 0, 0, 1);
            rd(3, {r3[15:8], b[7:0]});
            for (int j = 0; j < 6; j++) begin
                p = mulx(a, (j >= 4) ? {11'h000, s[4:0]} : b, sxs[j], sys[j]);
                op(pc[j], 1, 2, 12, s, 0, 0, 1);
                rd(12, p[15:0]);
                rd(13, p[31:16]);
            end
        end
        op(op_push_reg, 0, 1, 0, 0, 0, 0, 1);
        op(op_push_reg, 0, 2, 0, 0, 0, 0, 1);
        chk(32'(stack_ptr), 32'(SP_RESET + 6'h02));
        op(op_pop_reg, 0, 0, 6, 0, 0, 0, 1);
        rd(6, b);
        op(op_pop_file, 0, 0, 0, 0, 0, 6'h05, 1);
        chk(32'(stack_ptr), 32'(SP_RESET));
        fl = {a[0], 2'b00, (a >> 1) == 16'h0000, 1'b0};
        op(op_lsr_file_to_default_working_register, 0, 0, 0, 0, 0, 6'h05, 1);
        rd(DEFAULT_DEFAULT_WORKING_REGISTER, a >> 1);
        op(op_push_double, 12, 12, 12, 0, 0, 0, 2);
        chk(32'(stack_ptr), 32'(SP_RESET + 6'h02));
        op(op_pop_double, 8, 8, 8, 0, 0, 0, 2);
        rd(8, p[15:0]);
        rd(9, p[31:16]);
        op(op_copy_lit16, 0, 0, 10, 16'h0030, 0, 0, 1);
        // Offset below the base lands well clear of the stack area
        op(op_copy_store_offset, 10, 1, 1, 0, 10'h3D8, 0, 1);
        op(op_copy_load_offset, 11, 11, 7, 0, 10'h008, 0, 1);
        rd(7, a);
        op(op_double_copy_to_mem, 8, 8, 10, 0, 0, 0, 2);
        op(op_double_copy_from_mem, 10, 10, 14, 0, 0, 0, 2);
        rd(14, p[15:0]);
        rd(15, p[31:16]);
        // Enable held low: a standing request must leave no trace
        @(posedge sys_clk);
        ce       <= 1'b0;
        op_valid <= 1'b1;
        op_code  <= op_copy_lit16;
        dst_sel  <= 4'h7;
        literal  <= ~a;
        repeat (3) @(posedge sys_clk);
        op_valid <= 1'b0;
        ce       <= 1'b1;
        #1;
        chk(32'(done), 32'h0);
        rd(7, a);
        // A request still standing in the second cycle of a double push is ignored
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_code  <= op_push_double;
        src_sel  <= 4'hC;
        @(posedge sys_clk);
        op_code  <= op_pop_reg;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
        chk(32'({busy, done}), 32'h1);
        chk(32'(stack_ptr), 32'(SP_RESET + 6'h02));
        op(op_pop_reg, 0, 0, 6, 0, 0, 0, 1);
        rd(6, p[31:16]);
        // Reset in mid-run restores pointer, registers and flags
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk(32'(stack_ptr), 32'(SP_RESET));
        fl = 5'h00;
        rd(6, 16'h0000);
        op(op_pop_reg, 0, 0, 6, 0, 0, 0, 1);
        chk(32'(stack_ptr), 32'(SP_RESET - 6'h01));
        end_sim;
    end
endmodule // cpu_shift_move_mul_stack_ops_bench
`default_nettype wire
